// File: rtl/iprl_map.svh
`ifndef IPRL_MAP_SVH
`define IPRL_MAP_SVH

// ****************************************************************
// Register word indices on the Avalon-MM slave (byte address = 4x).
// ****************************************************************
`define IPRL_IDX_PRIO_A 3'h0
`define IPRL_IDX_PRIO_B 3'h1
`define IPRL_IDX_FLAGS 3'h2
`define IPRL_IDX_ENABLES 3'h3
`define IPRL_IDX_SENSE 3'h4

// ****************************************************************
// Reset values and field positions.
// ****************************************************************
`define IPRL_RST_BYTE 8'h00
`define IPRL_RST_PINS 6'h00
`define IPRL_PIN_IDLE 6'h3f
`define IPRL_FLAG_LSB 0
`define IPRL_FLAG_MSB 5
`define IPRL_FLAGS_RSVD 2'h0
`define IPRL_RD_PAD 24'h000000
`define IPRL_BE_LOW 0

// Priority register A field positions.
`define IPRL_A_PIN0 7
`define IPRL_A_PIN1 6
`define IPRL_A_PIN23 5
`define IPRL_A_PIN45 4
`define IPRL_A_WDOG_ADC 3
`define IPRL_A_T16_CH0 2
`define IPRL_A_T16_CH1 1
`define IPRL_A_T16_CH2 0
// Priority register B field positions.
`define IPRL_B_T8_CH01 7
`define IPRL_B_T8_CH23 6
`define IPRL_B_SERIAL0 3
`define IPRL_B_SERIAL1 2

// ****************************************************************
// Source counts, vectors and the module group of each internal source.
// ****************************************************************
`define IPRL_NPINS 6
`define IPRL_NINT 27
`define IPRL_PIN_VEC_BASE 6'h0c
`define IPRL_INT_VEC_BASE 6'h14
`define IPRL_VEC_NONE 6'h3f
`define IPRL_GRP_W 4
// Four bits per internal source, source 26 in the top nibble.
`define IPRL_GRP_TABLE 108'h877666655550444033302221001

`endif

// File: rtl/iprl_pkg.sv
package iprl_pkg;

	// Avalon-MM request from the bus master.
	typedef struct packed {
		logic read;
		logic write;
		logic [2:0] address;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} iprl_avs_req_t;

	// Request handed to the CPU exception logic.
	typedef struct packed {
		logic valid;
		logic [5:0] vector;
		logic level;
	} iprl_cpu_req_t;

	// Acknowledge of exception handling from the CPU.
	typedef struct packed {
		logic valid;
		logic [5:0] vector;
	} iprl_cpu_ack_t;

	// Module groups that share one priority bit; IPRL_GRP_FIXED has no bit and stays at level 0.
	typedef enum logic [3:0] {
		IPRL_GRP_FIXED,
		IPRL_GRP_WDOG_ADC,
		IPRL_GRP_T16_CH0,
		IPRL_GRP_T16_CH1,
		IPRL_GRP_T16_CH2,
		IPRL_GRP_T8_CH01,
		IPRL_GRP_T8_CH23,
		IPRL_GRP_SERIAL0,
		IPRL_GRP_SERIAL1
	} iprl_grp_t;

	// Whole state of the controller.
	typedef struct packed {
		logic [7:0] prio_a;
		logic [7:0] prio_b;
		logic [5:0] flags;
		logic [7:0] enables;
		logic [7:0] sense;
		logic [5:0] armed;
		logic [5:0] sync1;
		logic [5:0] sync2;
		logic [5:0] prev;
		logic ack;
		logic [31:0] rdata;
		iprl_cpu_req_t req;
	} iprl_state_t;

endpackage

// File: rtl/iprl.sv
`timescale 1ns/1ps
`default_nettype none
`include "iprl_map.svh"

module iprl (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Hardware standby request.
	input wire logic i_hw_standby,
	// Avalon-MM slave.
	input wire iprl_pkg::iprl_avs_req_t i_avs,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// External request pins, active low.
	input wire logic [5:0] i_pin_req_b,
	// Internal module requests.
	input wire logic [26:0] i_int_req,
	// CPU exception interface.
	output iprl_pkg::iprl_cpu_req_t o_cpu_req,
	input wire iprl_pkg::iprl_cpu_ack_t i_cpu_ack
);
	import iprl_pkg::*;

	localparam logic [`IPRL_GRP_W*`IPRL_NINT-1:0] GRP_TABLE = `IPRL_GRP_TABLE;

	iprl_state_t st_r;
	iprl_state_t st_nxt;
	logic [8:0] grp_level;
	logic [26:0] int_level;
	logic [5:0] pin_level;
	logic [5:0] pin_pend;
	logic access;
	logic take;
	logic hit_flags;

	// ****************************************************************
	// Priority levels per module group and per source.
	// ****************************************************************

	// Reserved bits of priority register B are not looked at here; register A has none.
	always_comb begin
		grp_level = '0;
		grp_level[IPRL_GRP_WDOG_ADC] = st_r.prio_a[`IPRL_A_WDOG_ADC];
		grp_level[IPRL_GRP_T16_CH0] = st_r.prio_a[`IPRL_A_T16_CH0];
		grp_level[IPRL_GRP_T16_CH1] = st_r.prio_a[`IPRL_A_T16_CH1];
		grp_level[IPRL_GRP_T16_CH2] = st_r.prio_a[`IPRL_A_T16_CH2];
		grp_level[IPRL_GRP_T8_CH01] = st_r.prio_b[`IPRL_B_T8_CH01];
		grp_level[IPRL_GRP_T8_CH23] = st_r.prio_b[`IPRL_B_T8_CH23];
		grp_level[IPRL_GRP_SERIAL0] = st_r.prio_b[`IPRL_B_SERIAL0];
		grp_level[IPRL_GRP_SERIAL1] = st_r.prio_b[`IPRL_B_SERIAL1];
	end

	// Each internal source looks up its group in the constant table.
	genvar gi;
	generate
		for (gi = 0; gi < `IPRL_NINT; gi++) begin : g_int
			assign int_level[gi] =
				grp_level[GRP_TABLE[gi*`IPRL_GRP_W +: `IPRL_GRP_W]];
		end
	endgenerate

	// Pins share bits pairwise above pin 1.
	assign pin_level = {st_r.prio_a[`IPRL_A_PIN45],
		st_r.prio_a[`IPRL_A_PIN45], st_r.prio_a[`IPRL_A_PIN23],
		st_r.prio_a[`IPRL_A_PIN23], st_r.prio_a[`IPRL_A_PIN1],
		st_r.prio_a[`IPRL_A_PIN0]};

	// A flag only requests while its pin is enabled.
	assign pin_pend = st_r.flags
		& st_r.enables[`IPRL_FLAG_MSB:`IPRL_FLAG_LSB];

	// ****************************************************************
	// Bus handshake.
	// ****************************************************************

	// One wait state: read data is captured first, then the access ends.
	assign access = i_avs.read | i_avs.write;
	assign take = access & st_r.ack;
	assign hit_flags = i_avs.address == `IPRL_IDX_FLAGS;
	assign o_avs_waitrequest = access & ~st_r.ack;
	assign o_avs_readdata = st_r.rdata;
	assign o_cpu_req = st_r.req;

	// ****************************************************************
	// Next state.
	// ****************************************************************

	always_comb begin
		logic wr_lane;
		logic [7:0] wbyte;
		logic [5:0] sw_clear;
		logic [5:0] hw_clear;
		logic [5:0] hw_set;
		logic found;
		st_nxt = st_r;
		wr_lane = i_avs.write & i_avs.byteenable[`IPRL_BE_LOW] & take;
		wbyte = i_avs.writedata[7:0];
		sw_clear = '0;
		hw_clear = '0;
		hw_set = '0;
		found = 1'b0;

		// Synchroniser chain; the first stage feeds only the second.
		st_nxt.sync1 = i_pin_req_b;
		st_nxt.sync2 = st_r.sync1;
		st_nxt.prev = st_r.sync2;

		st_nxt.ack = access & ~st_r.ack;

		// Read data is latched while waitrequest is still high.
		if (i_avs.read & ~st_r.ack) begin
			unique case (i_avs.address)
			`IPRL_IDX_PRIO_A: st_nxt.rdata = {`IPRL_RD_PAD, st_r.prio_a};
			`IPRL_IDX_PRIO_B: st_nxt.rdata = {`IPRL_RD_PAD, st_r.prio_b};
			`IPRL_IDX_FLAGS: st_nxt.rdata = {`IPRL_RD_PAD,
				`IPRL_FLAGS_RSVD, st_r.flags};
			`IPRL_IDX_ENABLES: st_nxt.rdata = {`IPRL_RD_PAD, st_r.enables};
			`IPRL_IDX_SENSE: st_nxt.rdata = {`IPRL_RD_PAD, st_r.sense};
			default: st_nxt.rdata = '0;
			endcase
		end

		// Plain storage registers; reserved bits are kept as written.
		if (wr_lane) begin
			unique case (i_avs.address)
			`IPRL_IDX_PRIO_A: st_nxt.prio_a = wbyte;
			`IPRL_IDX_PRIO_B: st_nxt.prio_b = wbyte;
			`IPRL_IDX_ENABLES: st_nxt.enables = wbyte;
			`IPRL_IDX_SENSE: st_nxt.sense = wbyte;
			default: ;
			endcase
		end

		// Clear arms on a read of 1; a written 0 then clears, a 1 never sets.
		if (take & i_avs.read & hit_flags)
			st_nxt.armed = st_r.rdata[`IPRL_FLAG_MSB:`IPRL_FLAG_LSB];
		if (wr_lane & hit_flags) begin
			sw_clear = st_r.armed & ~wbyte[`IPRL_FLAG_MSB:`IPRL_FLAG_LSB];
			st_nxt.armed = '0;
		end

		for (int n = 0; n < `IPRL_NPINS; n++) begin
			// Low level or falling edge of the synchronised pin.
			if (st_r.sense[n])
				hw_set[n] = st_r.prev[n] & ~st_r.sync2[n];
			else
				hw_set[n] = ~st_r.sync2[n];
			// Exception handling for this pin's vector.
			if (i_cpu_ack.valid &&
				i_cpu_ack.vector == `IPRL_PIN_VEC_BASE + 6'(n))
				hw_clear[n] = st_r.sense[n] | st_r.sync2[n];
		end
		// Setting wins over any clear in the same cycle except standby.
		st_nxt.flags = (st_r.flags & ~(sw_clear | hw_clear)) | hw_set;

		// Level 1 first, then smaller vector; the scan runs high to low.
		st_nxt.req.valid = 1'b0;
		st_nxt.req.vector = `IPRL_VEC_NONE;
		st_nxt.req.level = 1'b0;
		for (int lv = 1; lv >= 0; lv--) begin
			for (int k = `IPRL_NINT - 1; k >= 0; k--) begin
				if (!found && i_int_req[k] && int_level[k] == lv[0]) begin
					st_nxt.req.valid = 1'b1;
					st_nxt.req.vector = `IPRL_INT_VEC_BASE + 6'(k);
					st_nxt.req.level = lv[0];
				end
			end
			for (int n = `IPRL_NPINS - 1; n >= 0; n--) begin
				if (!found && pin_pend[n] && pin_level[n] == lv[0]) begin
					st_nxt.req.valid = 1'b1;
					st_nxt.req.vector = `IPRL_PIN_VEC_BASE + 6'(n);
					st_nxt.req.level = lv[0];
				end
			end
			found = st_nxt.req.valid;
		end

		// Standby returns the bus registers and the arm bits to their reset values.
		if (i_hw_standby) begin
			st_nxt.prio_a = `IPRL_RST_BYTE;
			st_nxt.prio_b = `IPRL_RST_BYTE;
			st_nxt.flags = `IPRL_RST_PINS;
			st_nxt.enables = `IPRL_RST_BYTE;
			st_nxt.sense = `IPRL_RST_BYTE;
			st_nxt.armed = `IPRL_RST_PINS;
		end
	end

	// ****************************************************************
	// State register.
	// ****************************************************************

	// Pins idle high, so the chain resets to ones to avoid a false edge.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r <= '0;
			st_r.sync1 <= `IPRL_PIN_IDLE;
			st_r.sync2 <= `IPRL_PIN_IDLE;
			st_r.prev <= `IPRL_PIN_IDLE;
			st_r.req.vector <= `IPRL_VEC_NONE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************************************
	// Checks.
	// ****************************************************************

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	property p_level_set;
		!i_hw_standby && !st_r.sense[0] && !st_r.sync2[0] |=> st_r.flags[0];
	endproperty
	a_level_set: assert property (p_level_set)
		else $error("Low pin in level mode did not set its flag.");

	property p_edge_set;
		!i_hw_standby && st_r.sense[1] && st_r.prev[1] && !st_r.sync2[1]
			|=> st_r.flags[1];
	endproperty
	a_edge_set: assert property (p_edge_set)
		else $error("Falling edge did not set its flag.");

	property p_pin_path;
		!i_hw_standby && !st_r.sense[2] && $fell(i_pin_req_b[2])
			|-> ##3 st_r.flags[2];
	endproperty
	a_pin_path: assert property (p_pin_path)
		else $error("Pin low did not reach its flag in three cycles.");

	property p_no_set_by_one;
		!st_r.flags[3] && st_r.sync2[3] && st_r.prev[3]
			|=> !st_r.flags[3];
	endproperty
	a_no_set_by_one: assert property (p_no_set_by_one)
		else $error("Flag rose without a pin event.");

	property p_unarmed;
		take && i_avs.write && hit_flags && !st_r.armed[4] && st_r.flags[4]
			|=> st_r.flags[4];
	endproperty
	a_unarmed: assert property (p_unarmed)
		else $error("Flag cleared by a write without a prior read.");

	property p_edge_ack;
		!i_hw_standby && st_r.sense[5] && st_r.flags[5] && i_cpu_ack.valid
			&& i_cpu_ack.vector == `IPRL_PIN_VEC_BASE + 6'h5
			&& !(st_r.prev[5] && !st_r.sync2[5]) |=> !st_r.flags[5];
	endproperty
	a_edge_ack: assert property (p_edge_ack)
		else $error("Edge flag survived exception handling.");

	property p_level_ack;
		!st_r.sense[0] && !st_r.sync2[0] && i_cpu_ack.valid
			|=> st_r.flags[0];
	endproperty
	a_level_ack: assert property (p_level_ack)
		else $error("Level flag cleared while pin still low.");

	property p_rsvd_zero;
		take && i_avs.read && hit_flags |-> o_avs_readdata[7:6] == 2'h0;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero)
		else $error("Reserved flag bits read nonzero.");

	property p_standby;
		i_hw_standby |=> st_r.prio_b == 8'h00 && st_r.flags == 6'h00
			&& st_r.enables == 8'h00 && st_r.sense == 8'h00;
	endproperty
	a_standby: assert property (p_standby)
		else $error("Standby did not clear the registers.");

	property p_disabled;
		$past(st_r.enables[5:0]) == 6'h00 && $past(i_int_req) == 27'h0
			&& $past(st_r.flags) != 6'h00 |-> !st_r.req.valid;
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("Disabled pin produced a request.");

	property p_pin_vec;
		i_int_req == '0 && pin_pend == 6'h30 && pin_level[5:4] == 2'h0
			|=> st_r.req.valid && st_r.req.vector == 6'h10;
	endproperty
	a_pin_vec: assert property (p_pin_vec)
		else $error("Wrong vector for equal-level pins.");

	property p_high_wins;
		i_int_req == 27'h0000001 && st_r.prio_a[3]
			&& st_r.prio_a[7:4] == 4'h0 && pin_pend != 6'h00
			|=> st_r.req.vector == 6'h14 && st_r.req.level;
	endproperty
	a_high_wins: assert property (p_high_wins)
		else $error("Level 1 watchdog request lost to a pin.");

	// Storage bits must hold exactly what was written, reserved ones too.
	property p_prio_b_store;
		!i_hw_standby && take && i_avs.write && i_avs.byteenable[0]
			&& i_avs.address == `IPRL_IDX_PRIO_B
			|=> st_r.prio_b == $past(i_avs.writedata[7:0]);
	endproperty
	a_prio_b_store: assert property (p_prio_b_store)
		else $error("Priority B byte did not store as written.");

	property p_enable_store;
		!i_hw_standby && take && i_avs.write && i_avs.byteenable[0]
			&& i_avs.address == `IPRL_IDX_ENABLES
			|=> st_r.enables == $past(i_avs.writedata[7:0]);
	endproperty
	a_enable_store: assert property (p_enable_store)
		else $error("Enable byte did not store as written.");

	property p_sense_store;
		!i_hw_standby && take && i_avs.write && i_avs.byteenable[0]
			&& i_avs.address == `IPRL_IDX_SENSE
			|=> st_r.sense == $past(i_avs.writedata[7:0]);
	endproperty
	a_sense_store: assert property (p_sense_store)
		else $error("Sense byte did not store as written.");

	// A pin that simply stays low must not set again in edge mode.
	property p_edge_steady;
		st_r.sense[1] && !st_r.prev[1] && !st_r.sync2[1]
			&& !st_r.flags[1] |=> !st_r.flags[1];
	endproperty
	a_edge_steady: assert property (p_edge_steady)
		else $error("Steady low pin set a flag in edge mode.");

	property p_pin0_vec;
		i_int_req == 27'h0 && pin_pend == 6'h01
			|=> st_r.req.valid && st_r.req.vector == 6'h0c;
	endproperty
	a_pin0_vec: assert property (p_pin0_vec)
		else $error("First pin did not request its own vector.");

	property p_rdata_pad;
		take && i_avs.read |-> o_avs_readdata[31:8] == 24'h0;
	endproperty
	a_rdata_pad: assert property (p_rdata_pad)
		else $error("Upper read data bits are not zero.");

	c_sw_clear: cover property (take && i_avs.write && hit_flags
		&& st_r.armed != 6'h00 ##1 st_r.flags == 6'h00);
	c_edge_flag: cover property (st_r.sense[0] && st_r.prev[0]
		&& !st_r.sync2[0]);
	c_level1_req: cover property (st_r.req.valid && st_r.req.level);
	c_pin_pair: cover property (pin_pend == 6'h30 && i_int_req == 27'h0);
	c_level_clear: cover property (i_cpu_ack.valid
		&& (st_r.flags & ~st_r.sense[5:0] & st_r.sync2) != 6'h00);

endmodule
`default_nettype wire

// File: testbench/iprl_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// CPU exception logic: takes the best pending request after a delay.
module iprl_cpu_model (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Control from the bench.
	input wire logic i_en,
	input wire logic [3:0] i_dly,
	// Request in, acknowledge out.
	input wire iprl_pkg::iprl_cpu_req_t i_req,
	output iprl_pkg::iprl_cpu_ack_t o_ack
);
	import iprl_pkg::*;
	logic [3:0] cnt_r;

	// A fresh wait after each ack lets the registered request settle.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_r <= 4'h0;
			o_ack <= {1'b0, 6'h3f};
		end else begin
			// Each signal is assigned once per edge.
			if (i_en && i_req.valid && cnt_r == i_dly) begin
				o_ack <= {1'b1, i_req.vector};
			end else begin
				o_ack.valid <= 1'b0;
				// A stale vector never looks like a fresh one.
				o_ack.vector <= ~o_ack.vector;
			end
			if (i_en && i_req.valid && cnt_r != i_dly) begin
				cnt_r <= cnt_r + 4'h1;
			end else begin
				cnt_r <= 4'h0;
			end
		end
	end
endmodule
`default_nettype wire

// File: testbench/iprl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "iprl_map.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
 $display("[ERR] %0t got %h expected %h", $time, g, e); end end
module iprl_tb_top;
	import iprl_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic stby = 1'b0;
	logic ack_en = 1'b0;
	logic [3:0] dly = 4'h0;
	logic [5:0] pins = 6'h3f;
	logic [26:0] ireq = 27'h0;
	iprl_avs_req_t avs = '0;
	logic [31:0] rdata;
	logic waitreq;
	iprl_cpu_req_t cpu_req;
	iprl_cpu_ack_t cpu_ack;
	int n_fail = 0;
	int n_tests = 0;
	int cyc = 0;
	logic [2:0] rw_idx [4] = '{3'h0, 3'h1, 3'h3, 3'h4};
	logic [4:0] src_k [8] = '{5'd3, 5'd4, 5'd8, 5'd12, 5'd16, 5'd20,
		5'd24, 5'd26};
	logic [2:0] bit_k [8] = '{3'd3, 3'd2, 3'd1, 3'd0, 3'd7, 3'd6, 3'd3, 3'd2};
	logic [31:0] v;
	logic [7:0] d;
	int k;

	// Half period of 2 ns gives the 250 MHz clock.
	always #2 i_clk = ~i_clk;

	iprl DUT (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_hw_standby(stby),
		.i_avs(avs), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
		.i_pin_req_b(pins), .i_int_req(ireq), .o_cpu_req(cpu_req),
		.i_cpu_ack(cpu_ack));
	iprl_cpu_model cpu (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_en(ack_en),
		.i_dly(dly), .i_req(cpu_req), .o_ack(cpu_ack));

	// ****************************************************************
	// Bus tasks and expectations.
	// ****************************************************************
	// One idle edge first, so a release never meets a new request.
	task automatic bus(input logic wr, input logic [2:0] idx,
		input logic [7:0] wd, output logic [31:0] rd);
		@(posedge i_clk);
		avs <= {!wr, wr, idx, 4'hf, 24'h0, wd};
		// Only the bench timeout ends a wait that never completes.
		do begin
			@(posedge i_clk);
		end while (waitreq !== 1'b0);
		rd = rdata;
		avs.read <= 1'b0;
		avs.write <= 1'b0;
	endtask

	task automatic wr(input logic [2:0] idx, input logic [7:0] wd);
		logic [31:0] x;
		bus(1'b1, idx, wd, x);
	endtask

	function automatic iprl_cpu_req_t exp_req(input int vec, input logic hi);
		return {1'b1, 6'(vec), hi};
	endfunction

	// Verdict and end of run, reached from the sequence or the timeout.
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// A hang is cut short well beyond the expected run length.
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			final_report();
		end
	end

	// ****************************************************************
	// Main sequence.
	// ****************************************************************
	initial begin
		v = $urandom(86643);
		repeat (20) @(posedge i_clk);
		i_rst_b <= 1'b1;
		// Reset values, including the unmapped index 5.
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, 3'(i), 8'h00, v);
			`CHK(v, 32'h0)
		end
		$display("reset values done");
		for (int i = 0; i < 8; i++) begin
			d = 8'($urandom);
			wr(rw_idx[i % 4], d);
			bus(1'b0, rw_idx[i % 4], 8'h00, v);
			`CHK(v, {24'h0, d})
		end
		wr(`IPRL_IDX_FLAGS, 8'hff);
		wr(3'h5, 8'hff);
		bus(1'b0, `IPRL_IDX_FLAGS, 8'h00, v);
		`CHK(v, 32'h0)
		stby <= 1'b1;
		@(posedge i_clk);
		stby <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, rw_idx[i], 8'h00, v);
			`CHK(v, 32'h0)
		end
		$display("register access done");
		// Level sensing with the pin request masked, then enabled.
		k = $urandom_range(5, 0);
		wr(`IPRL_IDX_ENABLES, 8'hc0);
		pins[k] <= 1'b0;
		repeat (6) @(posedge i_clk);
		pins[k] <= 1'b1;
		bus(1'b0, `IPRL_IDX_FLAGS, 8'h00, v);
		`CHK(v, 32'h1 << k)
		`CHK(cpu_req.valid, 1'b0)
		wr(`IPRL_IDX_ENABLES, 8'h3f);
		repeat (3) @(posedge i_clk);
		`CHK(cpu_req, exp_req(12 + k, 1'b0))
		// A write of ones disarms; an unarmed zero must not clear.
		wr(`IPRL_IDX_FLAGS, 8'hff);
		wr(`IPRL_IDX_FLAGS, 8'h00);
		bus(1'b0, `IPRL_IDX_FLAGS, 8'h00, v);
		`CHK(v, 32'h1 << k)
		wr(`IPRL_IDX_FLAGS, 8'h00);
		bus(1'b0, `IPRL_IDX_FLAGS, 8'h00, v);
		`CHK(v, 32'h0)
		// Level flag cleared by exception handling with the pin high.
		pins[k] <= 1'b0;
		repeat (6) @(posedge i_clk);
		pins[k] <= 1'b1;
		dly <= 4'($urandom_range(7, 0));
		ack_en <= 1'b1;
		repeat (24) @(posedge i_clk);
		bus(1'b0, `IPRL_IDX_FLAGS, 8'h00, v);
		`CHK(v, 32'h0)
		ack_en <= 1'b0;
		$display("level sensing done");
		// Edge sensing on every pin; the pin stays low through the ack.
		wr(`IPRL_IDX_SENSE, 8'h3f);
		for (int p = 0; p < 6; p++) begin
			pins[p] <= 1'b0;
			repeat (6) @(posedge i_clk);
			`CHK(cpu_req, exp_req(12 + p, 1'b0))
			dly <= 4'($urandom_range(7, 0));
			ack_en <= 1'b1;
			repeat (24) @(posedge i_clk);
			ack_en <= 1'b0;
			bus(1'b0, `IPRL_IDX_FLAGS, 8'h00, v);
			`CHK(v, 32'h0)
			pins[p] <= 1'b1;
		end
		$display("edge sensing done");
		// Two pins fall together; the smaller vector goes first.
		@(posedge i_clk);
		pins[5:4] <= 2'h0;
		repeat (6) @(posedge i_clk);
		`CHK(cpu_req, exp_req(16, 1'b0))
		ireq <= 27'h1;
		wr(`IPRL_IDX_PRIO_A, 8'h08);
		repeat (3) @(posedge i_clk);
		`CHK(cpu_req, exp_req(20, 1'b1))
		ireq <= 27'h0;
		pins[5:4] <= 2'h3;
		// Standby held until the raised pins have passed the chain.
		stby <= 1'b1;
		repeat (3) @(posedge i_clk);
		stby <= 1'b0;
		$display("pin order done");
		// Each priority bit lifts its group over a fixed low source.
		wr(`IPRL_IDX_ENABLES, 8'h00);
		wr(`IPRL_IDX_PRIO_A, 8'h00);
		wr(`IPRL_IDX_PRIO_B, 8'h33);
		ireq <= 27'h7ffffff;
		repeat (3) @(posedge i_clk);
		`CHK(cpu_req, exp_req(20, 1'b0))
		wr(`IPRL_IDX_PRIO_B, 8'h00);
		for (int g = 0; g < 8; g++) begin
			ireq <= 27'h2 | (27'h1 << src_k[g]);
			repeat (3) @(posedge i_clk);
			`CHK(cpu_req, exp_req(21, 1'b0))
			wr(g < 4 ? `IPRL_IDX_PRIO_A : `IPRL_IDX_PRIO_B, 8'h1 << bit_k[g]);
			repeat (3) @(posedge i_clk);
			`CHK(cpu_req, exp_req(20 + src_k[g], 1'b1))
			wr(g < 4 ? `IPRL_IDX_PRIO_A : `IPRL_IDX_PRIO_B, 8'h00);
		end
		$display("priority done");
		final_report();
	end
endmodule
`default_nettype wire
